// file: ccrc_board_model.sv
/*
 * Board side model: external reset driver and pll clock level source.
 * Assumes one free-running reference clock from the bench.
 */
module ccrc_board_model (
	// reference clock and reset request
	input wire logic clk_i,
	input wire logic hold_i,
	// pins toward the device
	output logic reset_n_o,
	output logic pll_clock_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] ph = 2'h0;
	// reset pin low from power-up, never floating
	initial begin
		reset_n_o = 1'b0;
		pll_clock_o = 1'b0;
	end
	// pll level toggles every four cycles so a stuck pin shows
	always @(posedge clk_i) begin
		reset_n_o <= ~hold_i;
		ph <= ph + 2'h1;
		if (ph == 2'h3) begin
			pll_clock_o <= ~pll_clock_o;
		end
	end
endmodule : ccrc_board_model

// file: ccrc_core_clock_reset.sv
/*
 * Core clock select and reset sequencing: strap sampling, pll setting,
 * lock wait, core reset and the shared reset-or-clock output pin.
 * Assumes clk_i is the free-running reference clock and the reset pin is
 * driven low at power-up by the board.
 */
// Implementation choices: the register offsets and strobed register access.
`include "ccrc_params.svh"

// Summary of operation
// - core runs from pll or straight from reference clock, per strap
// - start-up ratio is taken from the straps as reset releases
// - strap 00 is 3x, 01 is 16x, 10 is 8x, 11 reserved
// - software rewrites pll multiplier and divider once core is running
// - bit 12 picks pll clock or reset-out for shared pin; reset-out default
// - in reset-out mode the pin follows the core reset state
// - after reset release wait 4096 cycles, then start at reset vector
module ccrc_core_clock_reset #(
	parameter int LOCK_CYCLES = `CCRC_LOCK_CYCLES
) (
	// clock and resets
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic reset_n_i,
	// strap pins
	input wire logic [1:0] core_ratio_select_i,
	// pll clock from the analog macro, as a sampled level
	input wire logic pll_clock_i,
	// register port
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// core clocking and reset
	output logic core_bypass_o,
	output logic [5:0] core_mult_o,
	output logic [1:0] core_div_o,
	output logic core_reset_o,
	output logic core_start_o,
	// shared pin
	output logic reset_or_clock_out_o
);

	localparam int CW = $clog2(LOCK_CYCLES + 1);

	typedef struct packed {
		logic [1:0] strap_m;
		logic [1:0] strap_s;
		logic pll_m;
		logic pll_s;
		ccrc_pkg::ccrc_state_t state;
		logic [CW-1:0] cnt;
		logic [1:0] ratio;
		logic bypass;
		ccrc_pkg::ccrc_pll_cfg_t cfg;
		logic [31:0] rdata;
		logic core_reset;
		logic start;
		logic pin;
	} ccrc_state_all_t;

	ccrc_state_all_t q, next_q;
	logic pin_rst;

	// decode strap to start-up multiplier
	function automatic logic [5:0] ccrc_strap_mult(input logic [1:0] s);
		unique case (s)
			`CCRC_STRAP_3X: ccrc_strap_mult = `CCRC_MULT_3X;
			`CCRC_STRAP_16X: ccrc_strap_mult = `CCRC_MULT_16X;
			`CCRC_STRAP_8X: ccrc_strap_mult = `CCRC_MULT_8X;
			`CCRC_STRAP_RSV: ccrc_strap_mult = `CCRC_MULT_ONE;
		endcase
	endfunction : ccrc_strap_mult

	// reset pin: async assert, synchronised release
	ccrc_rst_sync ccrc_rst_sync_i (
		.clk_i(clk_i),
		.rst_n_i(reset_n_i),
		.rst_o(pin_rst)
	);

	// next state
	always_comb begin
		next_q = q;
		next_q.strap_m = core_ratio_select_i;
		next_q.strap_s = q.strap_m;
		next_q.pll_m = pll_clock_i;
		next_q.pll_s = q.pll_m;
		next_q.start = 1'b0;
		unique case (q.state)
			ccrc_pkg::CCRC_ST_RESET: begin
				// straps tracked while held; last value kept at release
				next_q.ratio = q.strap_s;
				// reserved code runs straight from reference clock
				next_q.bypass = (q.strap_s == `CCRC_STRAP_RSV);
				next_q.cfg.mult = ccrc_strap_mult(q.strap_s);
				next_q.cfg.div = '0;
				next_q.cfg.out_sel = 1'b0;
				next_q.cnt = '0;
				if (!pin_rst) begin
					next_q.state = ccrc_pkg::CCRC_ST_LOCK;
				end
			end
			ccrc_pkg::CCRC_ST_LOCK: begin
				next_q.cnt = q.cnt + CW'(1);
				if (q.cnt == CW'(LOCK_CYCLES - 1)) begin
					next_q.state = ccrc_pkg::CCRC_ST_RUN;
					next_q.core_reset = 1'b0;
					next_q.start = 1'b1;
				end
			end
			ccrc_pkg::CCRC_ST_RUN: begin
				// pll setting only writable while core is out of reset
				if (wr_i && addr_i == `CCRC_ADDR_POWER_MGMT_CTRL) begin
					next_q.cfg.mult =
						wdata_i[`CCRC_MULT_LSB +: `CCRC_MULT_W];
					next_q.cfg.div = wdata_i[`CCRC_DIV_LSB +: `CCRC_DIV_W];
					// bypass dropped once software programs the pll
					next_q.bypass = 1'b0;
				end
			end
			// unused fourth code: fall back to reset, never wedge
			default: next_q.state = ccrc_pkg::CCRC_ST_RESET;
		endcase
		// output select writable in any state; pin reset below clears it
		if (wr_i && addr_i == `CCRC_ADDR_POWER_MGMT_CTRL) begin
			next_q.cfg.out_sel = wdata_i[`CCRC_OUTSEL_BIT];
		end
		if (pin_rst) begin
			next_q.state = ccrc_pkg::CCRC_ST_RESET;
			next_q.core_reset = 1'b1;
			next_q.cfg.out_sel = 1'b0;
		end
		// read data, valid the cycle after the strobe only
		next_q.rdata = '0;
		if (rd_i) begin
			unique case (addr_i)
				`CCRC_ADDR_POWER_MGMT_CTRL: begin
					next_q.rdata[`CCRC_MULT_LSB +: `CCRC_MULT_W] = q.cfg.mult;
					next_q.rdata[`CCRC_DIV_LSB +: `CCRC_DIV_W] = q.cfg.div;
					next_q.rdata[`CCRC_OUTSEL_BIT] = q.cfg.out_sel;
				end
				`CCRC_ADDR_STATUS: begin
					next_q.rdata[`CCRC_ST_RUN_BIT] = ~q.core_reset;
					next_q.rdata[`CCRC_ST_BYP_BIT] = q.bypass;
					next_q.rdata[`CCRC_ST_RATIO_LSB +: `CCRC_ST_RATIO_W] =
						q.ratio;
				end
				default: next_q.rdata = '0; // unmapped reads as zero
			endcase
		end
		// shared pin: pll clock or core reset
		next_q.pin = q.cfg.out_sel ? q.pll_s : q.core_reset;
	end

	// one register for all state
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			q <= '0;
			q.state <= ccrc_pkg::CCRC_ST_RESET;
			q.core_reset <= 1'b1;
			q.pin <= 1'b1;
			q.cfg.mult <= `CCRC_MULT_ONE;
		end else begin
			q <= next_q;
		end
	end

	assign rdata_o = q.rdata;
	assign core_bypass_o = q.bypass;
	assign core_mult_o = q.cfg.mult;
	assign core_div_o = q.cfg.div;
	assign core_reset_o = q.core_reset;
	assign core_start_o = q.start;
	assign reset_or_clock_out_o = q.pin;

	// core leaves reset exactly after the full lock count; the counter
	// has already stepped past its last value when the pulse shows
	AST_LOCK_WAIT: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		$rose(core_start_o) |-> q.cnt == CW'(LOCK_CYCLES))
		else $error("core started before lock count ended");

	AST_START_PULSE: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		core_start_o |-> !core_reset_o ##1 !core_start_o)
		else $error("start pulse malformed");

	AST_PIN_RESET: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		!q.cfg.out_sel && $stable(q.cfg.out_sel)
		|-> ##1 reset_or_clock_out_o == $past(core_reset_o))
		else $error("shared pin not following core reset");

	AST_PIN_DEFAULT: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		pin_rst |=> !q.cfg.out_sel)
		else $error("shared pin not back to reset-out");

	// a write during the lock wait must leave the pll setting alone
	AST_NO_WR_IN_RESET: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		q.state == ccrc_pkg::CCRC_ST_LOCK && wr_i
		|=> $stable(core_mult_o) && $stable(core_div_o))
		else $error("pll changed while core in reset");

	AST_WRITE_TAKES: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		wr_i && addr_i == `CCRC_ADDR_POWER_MGMT_CTRL && !core_reset_o && !pin_rst
		|=> core_mult_o == $past(wdata_i[`CCRC_MULT_LSB +: `CCRC_MULT_W])
		&& !core_bypass_o)
		else $error("pll write not applied");

	AST_STRAP_MULT: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		q.state == ccrc_pkg::CCRC_ST_LOCK && q.ratio == `CCRC_STRAP_16X
		|-> core_mult_o == `CCRC_MULT_16X)
		else $error("16x strap gave wrong multiplier");

	AST_BYPASS_RSV: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		q.state == ccrc_pkg::CCRC_ST_LOCK
		|-> core_bypass_o == (q.ratio == `CCRC_STRAP_RSV))
		else $error("bypass disagrees with strap");

	AST_RELEASE_SYNC: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		q.state == ccrc_pkg::CCRC_ST_RESET && !pin_rst
		|=> q.state == ccrc_pkg::CCRC_ST_LOCK && q.cnt == '0)
		else $error("lock count did not begin after release");

endmodule : ccrc_core_clock_reset

// file: ccrc_core_clock_reset_bench.sv
/*
 * Bench: strap ratios, lock wait, shared pin and register port.
 * Assumes LOCK_CYCLES shortened to 16 and the board model beside it.
 */
`include "ccrc_params.svh"
module ccrc_core_clock_reset_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LOCK = 16;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic hold = 1'b1;
	logic reset_n, pll_clk, bypass, core_reset, start, pin;
	logic [1:0] strap = 2'h0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o;
	logic [5:0] mult;
	logic [1:0] div;
	logic [5:0] exp_mult [4] = '{`CCRC_MULT_3X, `CCRC_MULT_16X,
		`CCRC_MULT_8X, `CCRC_MULT_ONE};
	int error_cnt = 0;
	int n_compared = 0;
	// free-running reference clock, never stopped
	always #20 clk_i = ~clk_i;
	ccrc_core_clock_reset #(.LOCK_CYCLES(LOCK)) ccrc_core_clock_reset_i (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reset_n_i(reset_n),
		.core_ratio_select_i(strap), .pll_clock_i(pll_clk),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .core_bypass_o(bypass), .core_mult_o(mult),
		.core_div_o(div), .core_reset_o(core_reset),
		.core_start_o(start), .reset_or_clock_out_o(pin));
	ccrc_board_model ccrc_board_model_i (.clk_i(clk_i), .hold_i(hold),
		.reset_n_o(reset_n), .pll_clock_o(pll_clk));
	task automatic cmp(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= v;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		cmp("read data", e, rdata_o);
	endtask : rd
	// pin watched over four pll periods
	task automatic pin_seen(input logic elo, ehi);
		logic lo, hi;
		lo = 1'b0;
		hi = 1'b0;
		repeat (32) begin
			tick(1);
			lo |= (pin === 1'b0);
			hi |= (pin === 1'b1);
		end
		cmp("pin low seen", {31'h0, elo}, {31'h0, lo});
		cmp("pin high seen", {31'h0, ehi}, {31'h0, hi});
	endtask : pin_seen
	// reset with a strap, a refused write, then wait out the lock
	task automatic boot(input logic [1:0] s);
		int n;
		@(posedge clk_i);
		hold <= 1'b1;
		strap <= s;
		tick(4);
		cmp("pin in reset", 32'h1, {31'h0, pin});
		@(posedge clk_i);
		hold <= 1'b0;
		tick(5);
		// write lands in the lock wait, core still held: refused
		wr(`CCRC_ADDR_POWER_MGMT_CTRL, 32'h0000_0205);
		n = 7;
		while (start !== 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		cmp("lock wait", 32'h1, {31'h0, n >= LOCK && n <= LOCK + 8});
		cmp("core reset", 32'h0, {31'h0, core_reset});
		cmp("mult", {26'h0, exp_mult[s]}, {26'h0, mult});
		cmp("div", 32'h0, {30'h0, div});
		cmp("bypass", {31'h0, s == 2'h3}, {31'h0, bypass});
		tick(1);
		cmp("pin out of reset", 32'h0, {31'h0, pin});
		cmp("start pulse", 32'h0, {31'h0, start});
	endtask : boot
	task automatic tally_and_finish;
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish
	// main sequence: every strap code, then software clock setting
	initial begin
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		tick(1);
		cmp("pin after reset", 32'h1, {31'h0, pin});
		for (int s = 0; s < 4; s++) begin
			boot(2'(s));
		end
		rd(`CCRC_ADDR_STATUS, 32'h0000_0033);
		tick(1);
		cmp("read data gone", 32'h0, rdata_o);
		pin_seen(1'b1, 1'b0);
		wr(`CCRC_ADDR_POWER_MGMT_CTRL, 32'h0000_1010);
		tick(1);
		cmp("mult", 32'h10, {26'h0, mult});
		cmp("bypass", 32'h0, {31'h0, bypass});
		pin_seen(1'b1, 1'b1);
		wr(`CCRC_ADDR_POWER_MGMT_CTRL, 32'h0000_0205);
		tick(1);
		cmp("mult", 32'h05, {26'h0, mult});
		cmp("div", 32'h2, {30'h0, div});
		rd(`CCRC_ADDR_POWER_MGMT_CTRL, 32'h0000_0205);
		pin_seen(1'b1, 1'b0);
		wr(8'h08, 32'hffff_ffff);
		rd(8'h08, 32'h0);
		rd(`CCRC_ADDR_POWER_MGMT_CTRL, 32'h0000_0205);
		tally_and_finish();
	end
	// hang guard, far beyond the few hundred cycles needed
	initial begin
		#(40 * 3000);
		error_cnt++;
		tally_and_finish();
	end
endmodule : ccrc_core_clock_reset_bench

// file: ccrc_params.svh
/*
 * Constants for the core clock and reset control block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes it is included by bare name from the package and the modules.
 */
`ifndef CCRC_PARAMS_SVH
`define CCRC_PARAMS_SVH

// register offsets (byte addresses, word aligned)
`define CCRC_ADDR_POWER_MGMT_CTRL 8'h00
`define CCRC_ADDR_STATUS 8'h04

// power management control fields
`define CCRC_MULT_LSB 0
`define CCRC_MULT_W 6
`define CCRC_DIV_LSB 8
`define CCRC_DIV_W 2
`define CCRC_OUTSEL_BIT 12
`define CCRC_POWER_MGMT_CTRL_RST 32'h0000_0000

// status fields
`define CCRC_ST_RUN_BIT 0
`define CCRC_ST_BYP_BIT 1
`define CCRC_ST_RATIO_LSB 4
`define CCRC_ST_RATIO_W 2

// start-up ratios and strap codes
`define CCRC_STRAP_3X 2'h0
`define CCRC_STRAP_16X 2'h1
`define CCRC_STRAP_8X 2'h2
`define CCRC_STRAP_RSV 2'h3
`define CCRC_MULT_3X 6'h03
`define CCRC_MULT_16X 6'h10
`define CCRC_MULT_8X 6'h08
`define CCRC_MULT_ONE 6'h01

// pll lock latency, in reference clock cycles
`define CCRC_LOCK_CYCLES 4096

`endif

// file: ccrc_pkg.sv
/*
 * Types shared by the core clock and reset control block.
 * Assumes ccrc_params.svh is on the include path.
 */
`include "ccrc_params.svh"

package ccrc_pkg;

	// software clock setting
	typedef struct packed {
		logic out_sel;
		logic [`CCRC_DIV_W-1:0] div;
		logic [`CCRC_MULT_W-1:0] mult;
	} ccrc_pll_cfg_t;

	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} ccrc_bus_req_t;

	typedef enum logic [1:0] {
		CCRC_ST_RESET,
		CCRC_ST_LOCK,
		CCRC_ST_RUN
	} ccrc_state_t;

endpackage : ccrc_pkg

// file: ccrc_rst_sync.sv
/*
 * Reset synchroniser: asserts at once, releases after two clean edges.
 * Assumes rst_n_i is an asynchronous active-low pin.
 */
`include "ccrc_params.svh"

module ccrc_rst_sync (
	// clock and async reset pin
	input wire logic clk_i,
	input wire logic rst_n_i,
	// synchronised reset, active high
	output logic rst_o
);

	typedef struct packed {
		logic meta;
		logic hold;
	} ccrc_sync_t;

	ccrc_sync_t q;

	// assert asynchronously, release through two flops
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q.meta <= 1'b1;
			q.hold <= q.meta;
		end
	end

	assign rst_o = ~q.hold;

endmodule : ccrc_rst_sync
